// ### rtl/tce_error_checks.sv
// Purpose: drive timing error and non-executable function error detection
// Assumes: all inputs synchronous to clk; commands arrive as one-cycle strobes
// Notes: only two error register bits are held here, the rest read as zero
//
// Functional notes
// - write strobe late during write sets drive timing error.
// - transfer command while bus occupied sets drive timing error.
// - drive timing error is read-only, cleared by init or drive clear.
// - late strobe error: frame count already stepped since load.
// - bus-occupied error: frame count still holds loaded value.
// - drive timing error terminates any transfer in progress.
// - write to write-protected transport sets non-executable error.
// - reverse space, read or write-check at beginning of tape is non-executable.
// - density select disagreeing with capability status is non-executable.
// - space or write with frame count set flag clear is non-executable.
// - read/write, density clear, frame count magnitude below 13 is non-executable.
// - non-executable error read-only, cleared by drive clear or init.
// - non-executable error terminates any transfer in progress.
// - terminating error ends transfer; any error in transfer raises exception.
// - attention needs idle or rewinding and no motion command; no error arises then, so it stays low.
`timescale 1ns/10ps
`default_nettype none
module tce_error_checks
    import tce_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic bus_init,
    input wire logic cmd_valid,
    input wire logic [3:0] cmd_code,
    input wire logic bus_occupied_flag,
    input wire logic write_strobe_late,
    input wire logic write_protect,
    input wire logic beginning_of_tape,
    input wire logic density_select_bit,
    input wire logic pe_capable_status,
    input wire logic frame_count_set_flag,
    input wire logic fc_load,
    input wire logic [15:0] fc_load_value,
    input wire logic fc_step,
    input wire logic xfer_done,
    output logic [15:0] tape_error_flags,
    output logic [15:0] frame_count_register,
    output logic fc_stepped,
    output logic end_of_block_strobe,
    output logic exception_line,
    output logic attention_line,
    output logic cmd_abort,
    output logic op_active
);

    // ****************************************
    // command decoding
    // ****************************************
    function automatic logic is_xfer(input logic [3:0] c);
        case (c)
            TCE_CMD_WRITE, TCE_CMD_WCHK_FWD, TCE_CMD_WCHK_REV,
            TCE_CMD_READ_FWD, TCE_CMD_READ_REV: begin
                is_xfer = 1'b1;
            end
            default: begin
                is_xfer = 1'b0;
            end
        endcase
    endfunction

    function automatic logic is_read(input logic [3:0] c);
        case (c)
            TCE_CMD_READ_FWD, TCE_CMD_READ_REV: begin
                is_read = 1'b1;
            end
            default: begin
                is_read = 1'b0;
            end
        endcase
    endfunction

    function automatic logic is_space(input logic [3:0] c);
        case (c)
            TCE_CMD_SPC_FWD, TCE_CMD_SPC_REV: begin
                is_space = 1'b1;
            end
            default: begin
                is_space = 1'b0;
            end
        endcase
    endfunction

    function automatic logic is_reverse(input logic [3:0] c);
        case (c)
            TCE_CMD_SPC_REV, TCE_CMD_READ_REV, TCE_CMD_WCHK_REV: begin
                is_reverse = 1'b1;
            end
            default: begin
                is_reverse = 1'b0;
            end
        endcase
    endfunction

    function automatic logic is_write(input logic [3:0] c);
        case (c)
            TCE_CMD_WRITE: begin
                is_write = 1'b1;
            end
            default: begin
                is_write = 1'b0;
            end
        endcase
    endfunction

    // a drive clear is a command, not an operation: it never moves tape
    function automatic logic is_clear(input logic [3:0] c);
        case (c)
            TCE_CMD_DRV_CLR: begin
                is_clear = 1'b1;
            end
            default: begin
                is_clear = 1'b0;
            end
        endcase
    endfunction

    function automatic logic is_motion(input logic [3:0] c);
        is_motion = is_xfer(c) || is_space(c);
    endfunction

    // ****************************************
    // decode of the offered command
    // ****************************************
    logic clear_evt;
    logic motion_cmd;
    logic nef_cause;
    logic occ_cause;
    logic strobe_cause;
    logic dte_cause;
    logic any_new;
    logic writing;
    logic op_is_write;
    logic err_now;
    logic quiet_state;
    tce_state_type state;
    tce_state_type next_state;

    assign clear_evt = bus_init || (cmd_valid && is_clear(cmd_code));
    assign motion_cmd = cmd_valid && is_motion(cmd_code);

    always_comb begin
        nef_cause = 1'b0;
        if (motion_cmd) begin
            if (is_write(cmd_code) && write_protect) begin
                nef_cause = 1'b1;
            end
            if (is_reverse(cmd_code) && beginning_of_tape) begin
                nef_cause = 1'b1;
            end
            if (density_select_bit != pe_capable_status) begin
                nef_cause = 1'b1;
            end
            if ((is_space(cmd_code) || is_write(cmd_code)) && !frame_count_set_flag) begin
                nef_cause = 1'b1;
            end
            // negative count whose magnitude is 1..12
            if ((is_read(cmd_code) || is_write(cmd_code)) && !density_select_bit
                && frame_count_register > TCE_FC_MIN_NEG) begin
                nef_cause = 1'b1;
            end
        end
    end

    // occupied bus check happens before any frame count step
    assign occ_cause = cmd_valid && is_xfer(cmd_code) && bus_occupied_flag;
    // late strobe only counts once at least one frame went out
    assign writing = (state == TCE_ST_XFER) && op_is_write;
    assign strobe_cause = writing && write_strobe_late && fc_stepped;
    assign dte_cause = occ_cause || strobe_cause;
    assign any_new = (dte_cause && !tape_error_flags[TCE_DTE_BIT])
        || (nef_cause && !tape_error_flags[TCE_NEF_BIT]);

    // one terminating event, shared by end of block, abort and exception
    assign err_now = dte_cause || nef_cause;
    assign quiet_state = (state == TCE_ST_IDLE) || (state == TCE_ST_REWIND);

    // ****************************************
    // operation tracking
    // ****************************************
    always_comb begin
        next_state = state;
        if (clear_evt || dte_cause || nef_cause) begin
            next_state = TCE_ST_IDLE;
        end else if (cmd_valid) begin
            case (cmd_code)
                TCE_CMD_REWIND: next_state = TCE_ST_REWIND;
                TCE_CMD_SPC_FWD, TCE_CMD_SPC_REV: next_state = TCE_ST_SPACE;
                TCE_CMD_WRITE, TCE_CMD_WCHK_FWD, TCE_CMD_WCHK_REV,
                TCE_CMD_READ_FWD, TCE_CMD_READ_REV: next_state = TCE_ST_XFER;
                default: next_state = state;
            endcase
        end else if (xfer_done) begin
            next_state = TCE_ST_IDLE;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= TCE_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            op_is_write <= 1'b0;
        end else if (motion_cmd) begin
            op_is_write <= is_write(cmd_code);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            op_active <= 1'b0;
        end else begin
            op_active <= (next_state == TCE_ST_XFER) || (next_state == TCE_ST_SPACE);
        end
    end

    // ****************************************
    // frame count register
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            frame_count_register <= TCE_FC_RESET;
        end else if (fc_load) begin
            frame_count_register <= fc_load_value;
        end else if (fc_step && state != TCE_ST_IDLE && state != TCE_ST_REWIND) begin
            frame_count_register <= frame_count_register + 16'h0001;
        end
    end

    // remembers whether the count moved since the last load
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fc_stepped <= 1'b0;
        end else if (fc_load) begin
            fc_stepped <= 1'b0;
        end else if (fc_step && state != TCE_ST_IDLE && state != TCE_ST_REWIND) begin
            fc_stepped <= 1'b1;
        end
    end

    // ****************************************
    // error flags
    // ****************************************
    // set wins over a clear arriving in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tape_error_flags <= TCE_ERR_RESET;
        end else begin
            if (dte_cause) begin
                tape_error_flags[TCE_DTE_BIT] <= 1'b1;
            end else if (clear_evt) begin
                tape_error_flags[TCE_DTE_BIT] <= 1'b0;
            end
            if (nef_cause) begin
                tape_error_flags[TCE_NEF_BIT] <= 1'b1;
            end else if (clear_evt) begin
                tape_error_flags[TCE_NEF_BIT] <= 1'b0;
            end
        end
    end

    // ****************************************
    // controller signalling
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            end_of_block_strobe <= 1'b0;
            cmd_abort <= 1'b0;
        end else begin
            end_of_block_strobe <= err_now;
            cmd_abort <= err_now;
        end
    end

    // exception holds while an error sits in the register, until cleared
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            exception_line <= 1'b0;
        end else if (err_now) begin
            exception_line <= 1'b1;
        end else if (clear_evt) begin
            exception_line <= 1'b0;
        end
    end

    // attention only when idle or rewinding; a refused command is flagged by exception
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            attention_line <= 1'b0;
        end else if (any_new && !motion_cmd && quiet_state) begin
            attention_line <= 1'b1;
        end else if (clear_evt) begin
            attention_line <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ### rtl/tce_pkg.sv
// Purpose: constants and types for the tape command error checks
// Assumes: one 10 MHz clock, active-high asynchronous reset
// Notes: error register bit positions follow the tape error flag layout
package tce_pkg;

    // ****************************************
    // error register layout
    // ****************************************
    localparam int TCE_DTE_BIT = 12;
    localparam int TCE_NEF_BIT = 11;
    localparam logic [15:0] TCE_ERR_RESET = 16'h0000;

    // ****************************************
    // frame count limits
    // ****************************************
    localparam logic [15:0] TCE_FC_RESET = 16'h0000;
    // two's complement of 13: magnitudes below 13 lie above this value
    localparam logic [15:0] TCE_FC_MIN_NEG = 16'hfff3;

    // ****************************************
    // command codes
    // ****************************************
    typedef enum logic [3:0] {
        TCE_CMD_NONE      = 4'h0,
        TCE_CMD_DRV_CLR   = 4'h1,
        TCE_CMD_REWIND    = 4'h2,
        TCE_CMD_SPC_FWD   = 4'h3,
        TCE_CMD_SPC_REV   = 4'h4,
        TCE_CMD_WRITE     = 4'h5,
        TCE_CMD_WCHK_FWD  = 4'h6,
        TCE_CMD_WCHK_REV  = 4'h7,
        TCE_CMD_READ_FWD  = 4'h8,
        TCE_CMD_READ_REV  = 4'h9
    } tce_cmd_type;

    typedef enum logic [1:0] {
        TCE_ST_IDLE   = 2'b00,
        TCE_ST_REWIND = 2'b01,
        TCE_ST_XFER   = 2'b10,
        TCE_ST_SPACE  = 2'b11
    } tce_state_type;

endpackage

// ### tb/tce_ctrl_model.sv
// Purpose: bus controller stand-in for the error checks
// Assumes: bench says when the bus is held or a slot is missed
// Notes: plain wires, so a request lands in the cycle asked
`timescale 1ns/10ps
`default_nettype none
module tce_ctrl_model (
    input wire logic hold_bus,
    input wire logic miss_slot,
    output logic bus_occupied_flag,
    output logic write_strobe_late
);
    assign bus_occupied_flag = hold_bus;
    assign write_strobe_late = miss_slot;
endmodule
`default_nettype wire

// ### tb/tce_error_checks_assertions.sv
// Purpose: port checks for tce_error_checks
// Assumes: one clock, async active-high reset
// Notes: flags answer one cycle after cause
`timescale 1ns/10ps
`default_nettype none
module tce_error_checks_assertions
    import tce_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic bus_init,
    input wire logic cmd_valid,
    input wire logic [3:0] cmd_code,
    input wire logic bus_occupied_flag,
    input wire logic write_strobe_late,
    input wire logic write_protect,
    input wire logic beginning_of_tape,
    input wire logic [15:0] tape_error_flags,
    input wire logic end_of_block_strobe,
    input wire logic exception_line,
    input wire logic cmd_abort,
    input wire logic op_active
);
    // ********
    // checks
    // ********
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    logic clr;
    logic [1:0] flg;
    assign clr = bus_init || (cmd_valid && cmd_code == TCE_CMD_DRV_CLR);
    assign flg = tape_error_flags[12:11];
    busy_timing_a: assert property (
        cmd_valid && bus_occupied_flag && cmd_code inside {[4'h5:4'h9]} |=> flg[1]) else $error("busy missed");
    timing_cause_a: assert property (
        $rose(flg[1]) |-> $past(write_strobe_late) || $past(cmd_valid) && $past(bus_occupied_flag))
        else $error("timing no cause");
    timing_abort_a: assert property (
        $rose(flg[1]) |-> end_of_block_strobe && cmd_abort && exception_line) else $error("no abort");
    eob_pulse_a: assert property (
        end_of_block_strobe |-> cmd_abort ##1 !end_of_block_strobe && !op_active) else $error("eob long");
    flag_hold_a: assert property (
        !clr |=> (flg & $past(flg)) == $past(flg)) else $error("flag lost");
    protect_err_a: assert property (
        cmd_valid && write_protect && cmd_code == TCE_CMD_WRITE |=> flg[0]) else $error("protect missed");
    rev_start_a: assert property (
        cmd_valid && beginning_of_tape && cmd_code inside {4'h4, 4'h7, 4'h9} |=> flg[0]) else $error("rev missed");
    refuse_exc_a: assert property (
        $rose(flg[0]) |-> exception_line && !op_active) else $error("refuse bad");
    cover property ($rose(flg[1]));
    cover property ($rose(flg[0]));
    cover property ($fell(flg[1]));
endmodule
bind tce_error_checks tce_error_checks_assertions chk_i (
    .clk(clk),
    .rst(rst),
    .bus_init(bus_init),
    .cmd_valid(cmd_valid),
    .cmd_code(cmd_code),
    .bus_occupied_flag(bus_occupied_flag),
    .write_strobe_late(write_strobe_late),
    .write_protect(write_protect),
    .beginning_of_tape(beginning_of_tape),
    .tape_error_flags(tape_error_flags),
    .end_of_block_strobe(end_of_block_strobe),
    .exception_line(exception_line),
    .cmd_abort(cmd_abort),
    .op_active(op_active)
);
`default_nettype wire

// ### tb/tce_error_checks_bench.sv
// Purpose: directed bench for tce_error_checks
// Assumes: inputs move on the falling edge
// Notes: no random stimulus
`timescale 1ns/10ps
`default_nettype none
module tce_error_checks_bench
    import tce_pkg::*;
;
    logic clk, rst, bus_init, cmd_valid, fc_load, fc_step, xfer_done, hold_bus, miss_slot;
    logic write_protect, beginning_of_tape, density_select_bit, pe_capable_status, frame_count_set_flag;
    logic bus_occupied_flag, write_strobe_late, fc_stepped, end_of_block_strobe, exception_line;
    logic attention_line, cmd_abort, op_active;
    logic [3:0] cmd_code;
    logic [15:0] fc_load_value, tape_error_flags, frame_count_register;
    int n_mismatch = 0;
    int compares = 0;
    int cyc = 0;
    // refusal cases {protect, tape start, density, capable, count set}; last one is legal
    logic [4:0] cnd [10] = '{5'h17, 5'h0f, 5'h0f, 5'h0f, 5'h05, 5'h03, 5'h06, 5'h06, 5'h01, 5'h01};
    logic [3:0] cod [10] = '{4'h5, 4'h4, 4'h9, 4'h7, 4'h3, 4'h8, 4'h3, 4'h5, 4'h8, 4'h8};
    logic [9:0] bad = 10'h1ff;
    tce_error_checks dut (
        .clk(clk),
        .rst(rst),
        .bus_init(bus_init),
        .cmd_valid(cmd_valid),
        .cmd_code(cmd_code),
        .bus_occupied_flag(bus_occupied_flag),
        .write_strobe_late(write_strobe_late),
        .write_protect(write_protect),
        .beginning_of_tape(beginning_of_tape),
        .density_select_bit(density_select_bit),
        .pe_capable_status(pe_capable_status),
        .frame_count_set_flag(frame_count_set_flag),
        .fc_load(fc_load),
        .fc_load_value(fc_load_value),
        .fc_step(fc_step),
        .xfer_done(xfer_done),
        .tape_error_flags(tape_error_flags),
        .frame_count_register(frame_count_register),
        .fc_stepped(fc_stepped),
        .end_of_block_strobe(end_of_block_strobe),
        .exception_line(exception_line),
        .attention_line(attention_line),
        .cmd_abort(cmd_abort),
        .op_active(op_active)
    );
    tce_ctrl_model ctrl (
        .hold_bus(hold_bus),
        .miss_slot(miss_slot),
        .bus_occupied_flag(bus_occupied_flag),
        .write_strobe_late(write_strobe_late)
    );
    // ********
    // tasks
    // ********
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            n_mismatch++;
            end_sim();
        end
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic cmd(input logic [3:0] c);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_code = c;
        @(negedge clk);
        cmd_valid = 1'b0;
    endtask
    // {load, init, step, missed slot, done} for one cycle
    task automatic tick(input logic [4:0] v);
        @(negedge clk);
        {fc_load, bus_init, fc_step, miss_slot, xfer_done} = v;
        @(negedge clk);
        {fc_load, bus_init, fc_step, miss_slot, xfer_done} = 5'h00;
    endtask
    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        {bus_init, cmd_valid, cmd_code, fc_load, fc_load_value, fc_step, xfer_done, hold_bus, miss_slot} = '0;
        {write_protect, beginning_of_tape, density_select_bit, pe_capable_status, frame_count_set_flag} = 5'h07;
        rst = 1'b1;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        chk(tape_error_flags, TCE_ERR_RESET);
        fc_load_value = 16'hfff0;
        tick(5'h10);
        hold_bus = 1'b1;
        cmd(TCE_CMD_READ_FWD);
        hold_bus = 1'b0;
        chk(tape_error_flags, 16'h1000);
        chk({13'h0, end_of_block_strobe, exception_line, cmd_abort}, 16'h0007);
        chk(frame_count_register, 16'hfff0);
        chk({15'h0, attention_line}, 16'h0000);
        tick(5'h00);
        chk({13'h0, end_of_block_strobe, cmd_abort, op_active}, 16'h0000);
        chk(tape_error_flags, 16'h1000);
        cmd(TCE_CMD_DRV_CLR);
        chk(tape_error_flags, 16'h0000);
        chk({15'h0, exception_line}, 16'h0000);
        $display("test busy done");
        fc_load_value = 16'h0010;
        tick(5'h10);
        cmd(TCE_CMD_WRITE);
        tick(5'h04);
        chk(frame_count_register, 16'h0011);
        tick(5'h02);
        chk(tape_error_flags, 16'h1000);
        chk({12'h0, fc_stepped, end_of_block_strobe, exception_line, cmd_abort}, 16'h000f);
        tick(5'h08);
        chk(tape_error_flags, 16'h0000);
        $display("test late strobe done");
        tick(5'h10);
        cmd(TCE_CMD_READ_FWD);
        tick(5'h04);
        tick(5'h02);
        chk(tape_error_flags, 16'h0000);
        tick(5'h01);
        $display("test read strobe done");
        for (int i = 0; i < 10; i++) begin
            {write_protect, beginning_of_tape, density_select_bit, pe_capable_status, frame_count_set_flag} = cnd[i];
            fc_load_value = (i < 8) ? 16'h0010 : 16'hfff3 + 16'(9 - i);
            tick(5'h10);
            cmd(cod[i]);
            chk(tape_error_flags, {4'h0, bad[i], 11'h0});
            chk({15'h0, op_active}, {15'h0, ~bad[i]});
            cmd(TCE_CMD_DRV_CLR);
        end
        tick(5'h01);
        $display("test refusals done");
        end_sim();
    end
endmodule
`default_nettype wire
